// file: bench/capture_ch1_monitor.sv
module capture_ch1_monitor (
    // Bus and clock
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic ack_o,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    // Outputs under watch
    input wire logic clk_edge_sel_o,
    input wire logic wr_valid_o,
    input wire logic frame_irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==============================================================
    // Shadow of the low eleven bits
    logic [10:0] low_q;
    logic wr_ok;
    assign wr_ok = ack_o && we_i && adr_i == 4'h0;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Updated at the edge the master sees ack, as the register is
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_q <= 11'h000;
        end else if (wr_ok) begin
            if (sel_i[0]) low_q[7:0] <= dat_i[7:0];
            if (sel_i[1]) low_q[10:8] <= dat_i[10:8];
        end
    end
    // ==============================================================
    // Properties
    ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack late");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack too long");
    edge_load_a: assert property (wr_ok && sel_i[3] |=>
        clk_edge_sel_o == $past(dat_i[31])) else $error("edge bit");
    edge_hold_a: assert property (!(wr_ok && sel_i[3]) |=>
        $stable(clk_edge_sel_o)) else $error("edge moved");
    rsvd_zero_a: assert property (ack_o && !we_i |->
        dat_o[30:11] == 20'h0 && dat_o[4:3] == 2'h0)
        else $error("reserved set");
    irq_pulse_a: assert property (frame_irq_o |=> !frame_irq_o)
        else $error("irq long");
    prog_bottom_a: assert property (low_q[10] && low_q[7:6] == 2'h1 &&
        $past(low_q[10]) && $past(low_q[7:6]) == 2'h1 |-> !frame_irq_o)
        else $error("bottom irq in progressive");
    irq_off_a: assert property (!low_q[0] && !$past(low_q[0])
        |-> !frame_irq_o) else $error("irq while off");
    store_off_a: assert property (!low_q[0] && !$past(low_q[0])
        |-> !wr_valid_o) else $error("store while off");
    wr_pulse_a: assert property (wr_valid_o |=> !wr_valid_o)
        else $error("store long");
    cover property (frame_irq_o);
    cover property (wr_valid_o);
    cover property (ack_o && !we_i);
endmodule : capture_ch1_monitor

bind capture_second_capture_channel_control capture_ch1_monitor capture_ch1_monitor_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .ack_o(ack_o),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .clk_edge_sel_o(clk_edge_sel_o),
    .wr_valid_o(wr_valid_o),
    .frame_irq_o(frame_irq_o)
);

// file: bench/video_capture_ch1_control_test.sv
module video_capture_ch1_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    import capture_ch1_pkg::*;
    `define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin \
        errors++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
    // ==============================================================
    // Signals
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic we_i = 1'b0, ack_o, clk_edge_sel_o, wr_valid_o, frame_irq_o;
    logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, q, cfg;
    logic pix_clk_i, raw_vsync_i, raw_hsync_i, raw_field_i, fid, f, hit;
    pix_byte_t pix_data_i, wr_data_o, mb, b;
    pix_byte_t exp_q[$];
    int errors = 0, n_tests = 0, cycles = 0, irq_seen = 0, irq_exp = 0;
    always #25 clk_i = ~clk_i;
    capture_second_capture_channel_control capture_second_capture_channel_control_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .adr_i(adr_i),
        .sel_i(sel_i),
        .dat_i(dat_i),
        .dat_o(dat_o),
        .ack_o(ack_o),
        .pix_clk_i(pix_clk_i),
        .pix_data_i(pix_data_i),
        .raw_vsync_i(raw_vsync_i),
        .raw_hsync_i(raw_hsync_i),
        .raw_field_i(raw_field_i),
        .clk_edge_sel_o(clk_edge_sel_o),
        .wr_valid_o(wr_valid_o),
        .wr_data_o(wr_data_o),
        .frame_irq_o(frame_irq_o)
    );
    video_source video_source_inst (.pix_clk_o(pix_clk_i),
        .pix_data_o(pix_data_i), .vsync_o(raw_vsync_i),
        .hsync_o(raw_hsync_i), .field_o(raw_field_i));
    // ==============================================================
    // Tasks
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb
    // One line: blanking words, then active words, stored as enabled
    task automatic line(input logic v);
        video_source_inst.code(f, v, 1'b1);
        for (int k = 0; k < 6; k++) begin
            if (k == 3) video_source_inst.code(f, v, 1'b0);
            b = pix_byte_t'($urandom_range(254, 1));
            if (cfg[0] && (k < 3 ? cfg[8] : (!v || cfg[9])))
                exp_q.push_back(b);
            video_source_inst.put(b);
        end
    endtask : line
    // ==============================================================
    // Reference checks on every result
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 8000) begin
            errors++;
            results();
        end else begin
            if (frame_irq_o === 1'b1) irq_seen++;
            if (wr_valid_o === 1'b1) begin
                if (exp_q.size() == 0) begin
                    `CHK("extra store", 1'b0, 1'b1)
                end else begin
                    mb = exp_q.pop_front();
                    `CHK("store data", mb, wr_data_o)
                end
            end
        end
    end
    initial begin
        void'($urandom(52437));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 4'h0, 32'h0);
        `CHK("reset value", 32'h0, q)
        wb(1'b1, 4'h0, 32'hFFFF_FFBF);
        wb(1'b1, 4'h4, 32'h0);
        wb(1'b0, 4'h0, 32'h0);
        `CHK("all ones", 32'h8000_0787, q)
        `CHK("edge out", 1'b1, clk_edge_sel_o)
        wb(1'b0, 4'h4, 32'h0);
        `CHK("unmapped", 32'h0, q)
        wb(1'b1, 4'h0, 32'h0);
        @(posedge clk_i);
        `CHK("edge off", 1'b0, clk_edge_sel_o)
        $display("test registers done");
        fid = 1'b0;
        for (int i = 0; i < 9; i++) begin
            cfg = 32'h20 | (32'(i == 8) << 10) | (32'(i % 4) << 8);
            cfg = cfg | (32'(i == 8 ? 1 : i % 3) << 6) | 32'(i != 5);
            f = i[2] | (i == 8);
            wb(1'b1, 4'h0, cfg);
            line(1'b0);
            line(1'b1);
            hit = i != 5 && (cfg[7:6] == 2'h2 ||
                cfg[7:6] == {1'b0, (f && i != 8)});
            if (hit) begin
                irq_exp++;
                fid = f && i != 8;
            end
            repeat (8) @(posedge clk_i);
            wb(1'b0, 4'h0, 32'h0);
            `CHK("readback", (cfg & 32'h7C7) | (32'(fid) << 5), q)
            `CHK("irq count", irq_exp, irq_seen)
            `CHK("missing", 0, exp_q.size())
        end
        $display("test stream done");
        cfg = 32'h85;
        wb(1'b1, 4'h0, cfg);
        video_source_inst.field_o <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            video_source_inst.hsync_o <= (k == 3);
            b = pix_byte_t'($urandom_range(255, 0));
            if (k < 3) exp_q.push_back(b);
            video_source_inst.put(b);
        end
        video_source_inst.hsync_o <= 1'b0;
        video_source_inst.vsync_o <= 1'b1;
        irq_exp++;
        repeat (12) @(posedge clk_i);
        wb(1'b0, 4'h0, 32'h0);
        `CHK("raw field", 1'b1, q[5])
        `CHK("raw irq", irq_exp, irq_seen)
        `CHK("raw missing", 0, exp_q.size())
        video_source_inst.field_o <= 1'b0;
        repeat (8) @(posedge clk_i);
        wb(1'b0, 4'h0, 32'h0);
        `CHK("raw field low", 1'b0, q[5])
        $display("test raw done");
        results();
    end
endmodule : video_capture_ch1_control_test

// file: bench/video_source.sv
module video_source
    import capture_ch1_pkg::*;
(
    // Link pins
    output logic pix_clk_o,
    output pix_byte_t pix_data_o,
    // Raw sync pins
    output logic vsync_o,
    output logic hsync_o,
    output logic field_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==============================================================
    // Byte source
    initial begin
        pix_clk_o = 1'b0;
        pix_data_o = 8'h00;
        vsync_o = 1'b0;
        hsync_o = 1'b0;
        field_o = 1'b0;
    end
    // Clock runs only while a byte is offered
    task automatic put(input pix_byte_t b);
        #13 pix_data_o = b;
        #187 pix_clk_o = 1'b1;
        #200 pix_clk_o = 1'b0;
        // Stale byte must not linger after its hold time
        pix_data_o = ~b;
    endtask : put
    task automatic code(input logic f, input logic v, input logic h);
        put(8'hFF);
        put(8'h00);
        put(8'h00);
        put({1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h});
    endtask : code
endmodule : video_source

// file: rtl/capture_ch1_pkg.sv
package capture_ch1_pkg;

    // Gray-coded walk through the timing reference preamble
    typedef enum logic [1:0] {
        TRS_IDLE = 2'b00,
        TRS_FF1 = 2'b01,
        TRS_Z1 = 2'b11,
        TRS_Z2 = 2'b10
    } trs_state_e;

    typedef enum logic [1:0] {
        IRQ_TOP = 2'h0,
        IRQ_BOTTOM = 2'h1,
        IRQ_BOTH = 2'h2,
        IRQ_RSVD = 2'h3
    } irq_select_e;

    typedef logic [7:0] pix_byte_t;

endpackage : capture_ch1_pkg

// file: rtl/capture_ch1_regs.svh
`ifndef CAPTURE_CH1_REGS_SVH
`define CAPTURE_CH1_REGS_SVH

// ==================================================================
// Register map
`define CTRL_OFFSET 4'h0
`define CTRL_RESET 32'h0000_0000

// ==================================================================
// Field positions of the channel control register
`define EDGE_SEL_BIT 31
`define PROG_BIT 10
`define VANC_BIT 9
`define HANC_BIT 8
`define INT_SEL_HI 7
`define INT_SEL_LO 6
`define FIELD_BIT 5
`define FMT_HI 2
`define FMT_LO 1
`define ENABLE_BIT 0

// ==================================================================
// Stream timing codes
`define TRS_FF 8'hFF
`define TRS_00 8'h00
`define XY_F_BIT 6
`define XY_V_BIT 5
`define XY_H_BIT 4

`endif

// file: rtl/capture_second_capture_channel_control.sv
// The Wishbone slave port and the address map were decided locally.
`include "capture_ch1_regs.svh"

module capture_second_capture_channel_control (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Video link pins
    input wire logic pix_clk_i,
    input wire capture_ch1_pkg::pix_byte_t pix_data_i,
    input wire logic raw_vsync_i,
    input wire logic raw_hsync_i,
    input wire logic raw_field_i,
    // To pin-level edge logic
    output logic clk_edge_sel_o,
    // SDRAM write stream
    output logic wr_valid_o,
    output capture_ch1_pkg::pix_byte_t wr_data_o,
    // Frame event to CPU
    output logic frame_irq_o
);
    import capture_ch1_pkg::*;

    // ==================================================================
    // Control register fields
    logic edge_sel_q;
    logic prog_q;
    logic vanc_en_q;
    logic hanc_en_q;
    irq_select_e int_sel_q;
    logic field_flag_q;
    logic [1:0] fmt_q;
    logic enable_q;
    logic ack_q;
    logic [31:0] dat_q;

    // ==================================================================
    // Pin synchronisers
    logic [2:0] clk_meta_q;
    logic [2:0] clk_sync_q;
    pix_byte_t data_meta_q;
    pix_byte_t data_sync_q;
    logic vs_meta_q;
    logic vs_sync_q;
    logic vs_prev_q;
    logic pclk_prev_q;

    // ==================================================================
    // Stream pipeline
    logic pix_edge;
    logic raw_mode;
    logic code_byte;
    logic xy_seen;
    logic trs_field;
    logic trs_vblank;
    logic trs_hblank;
    logic vblank_prev_q;
    logic field_now;
    logic field_event;
    logic irq_fire;
    logic store;
    logic field_view;
    logic wb_req;
    logic wb_wr;
    logic addr_hit;
    logic wr_valid_q;
    pix_byte_t wr_data_q;
    logic irq_q;

    // Field decode is used by both sync sources
    function automatic logic irq_match(input irq_select_e sel,
                                       input logic bottom);
        case (sel)
            IRQ_TOP: irq_match = !bottom;
            IRQ_BOTTOM: irq_match = bottom;
            IRQ_BOTH: irq_match = 1'b1;
            default: irq_match = 1'b0;
        endcase
    endfunction : irq_match

    // ==================================================================
    // Two flops per pin, third flop only for edge detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_meta_q <= 3'h0;
            clk_sync_q <= 3'h0;
            vs_meta_q <= 1'b0;
            vs_sync_q <= 1'b0;
        end else begin
            clk_meta_q <= {raw_field_i, raw_hsync_i, pix_clk_i};
            clk_sync_q <= clk_meta_q;
            vs_meta_q <= raw_vsync_i;
            vs_sync_q <= vs_meta_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_meta_q <= 8'h00;
            data_sync_q <= 8'h00;
        end else begin
            data_meta_q <= pix_data_i;
            data_sync_q <= data_meta_q;
        end
    end

    // Idle pin levels are low, so no false edge follows reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pclk_prev_q <= 1'b0;
            vs_prev_q <= 1'b0;
        end else begin
            pclk_prev_q <= clk_sync_q[0];
            vs_prev_q <= vs_sync_q;
        end
    end

    // Rising edge of the synchronised pixel clock; the data captured
    // in the same cycle was stable for half a pixel period
    assign pix_edge = clk_sync_q[0] && !pclk_prev_q;
    assign raw_mode = fmt_q[1];

    trs_decoder trs_decoder_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .byte_valid_i(pix_edge && !raw_mode),
        .byte_i(data_sync_q),
        .code_byte_o(code_byte),
        .xy_seen_o(xy_seen),
        .field_o(trs_field),
        .vblank_o(trs_vblank),
        .hblank_o(trs_hblank)
    );

    // ==================================================================
    // Field boundary events
    // Progressive frames carry no bottom field
    assign field_now = prog_q ? 1'b0 :
        (raw_mode ? clk_sync_q[2] : data_sync_q[`XY_F_BIT]);
    assign field_event = raw_mode ? (vs_sync_q && !vs_prev_q)
        : (xy_seen && data_sync_q[`XY_V_BIT] && !vblank_prev_q);
    assign irq_fire = enable_q && field_event &&
        irq_match(int_sel_q, field_now);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vblank_prev_q <= 1'b0;
        end else if (xy_seen) begin
            vblank_prev_q <= data_sync_q[`XY_V_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_fire;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            field_flag_q <= 1'b0;
        end else if (irq_fire) begin
            field_flag_q <= field_now;
        end
    end

    assign field_view = raw_mode ? clk_sync_q[2] : field_flag_q;

    // ==================================================================
    // Word storage gate
    always_comb begin
        store = 1'b0;
        if (!enable_q || !pix_edge) begin
            store = 1'b0;
        end else if (raw_mode) begin
            store = !vs_sync_q && !clk_sync_q[1];
        end else if (code_byte) begin
            store = 1'b0;
        end else if (trs_hblank) begin
            store = hanc_en_q;
        end else if (trs_vblank) begin
            store = vanc_en_q;
        end else begin
            store = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_valid_q <= 1'b0;
            wr_data_q <= 8'h00;
        end else begin
            wr_valid_q <= store;
            if (store) wr_data_q <= data_sync_q;
        end
    end

    // ==================================================================
    // Wishbone slave: ack one cycle after the request, write at the edge that ends the ack cycle
    assign wb_req = cyc_i && stb_i;
    assign addr_hit = (adr_i == `CTRL_OFFSET);
    assign wb_wr = wb_req && we_i && ack_q && addr_hit;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= `CTRL_RESET;
        end else begin
            ack_q <= wb_req && !ack_q;
            if (wb_req && !ack_q && !we_i) begin
                dat_q <= 32'h0000_0000;
                if (addr_hit) begin
                    dat_q[`EDGE_SEL_BIT] <= edge_sel_q;
                    dat_q[`PROG_BIT] <= prog_q;
                    dat_q[`VANC_BIT] <= vanc_en_q;
                    dat_q[`HANC_BIT] <= hanc_en_q;
                    dat_q[`INT_SEL_HI:`INT_SEL_LO] <= int_sel_q;
                    dat_q[`FIELD_BIT] <= field_view;
                    dat_q[`FMT_HI:`FMT_LO] <= fmt_q;
                    dat_q[`ENABLE_BIT] <= enable_q;
                end
            end
        end
    end

    // Reserved bits and the field flag have no storage on the write path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_sel_q <= 1'b0;
            prog_q <= 1'b0;
            vanc_en_q <= 1'b0;
            hanc_en_q <= 1'b0;
            int_sel_q <= IRQ_TOP;
            fmt_q <= 2'h0;
            enable_q <= 1'b0;
        end else if (wb_wr) begin
            if (sel_i[3]) edge_sel_q <= dat_i[`EDGE_SEL_BIT];
            if (sel_i[1]) begin
                prog_q <= dat_i[`PROG_BIT];
                vanc_en_q <= dat_i[`VANC_BIT];
                hanc_en_q <= dat_i[`HANC_BIT];
            end
            if (sel_i[0]) begin
                int_sel_q <= irq_select_e'(dat_i[`INT_SEL_HI:`INT_SEL_LO]);
                fmt_q <= dat_i[`FMT_HI:`FMT_LO];
                enable_q <= dat_i[`ENABLE_BIT];
            end
        end
    end

    // ==================================================================
    // Outputs
    assign clk_edge_sel_o = edge_sel_q;
    assign dat_o = dat_q;
    assign ack_o = ack_q;
    assign wr_valid_o = wr_valid_q;
    assign wr_data_o = wr_data_q;
    assign frame_irq_o = irq_q;

endmodule : capture_second_capture_channel_control

// file: rtl/trs_decoder.sv
`include "capture_ch1_regs.svh"

module trs_decoder (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Incoming byte stream
    input wire logic byte_valid_i,
    input wire capture_ch1_pkg::pix_byte_t byte_i,
    // Decoded timing
    output logic code_byte_o,
    output logic xy_seen_o,
    output logic field_o,
    output logic vblank_o,
    output logic hblank_o
);
    import capture_ch1_pkg::*;

    trs_state_e state_q;
    logic field_q;
    logic vblank_q;
    logic hblank_q;

    // ==================================================================
    // Classification of the present byte
    // FF and 00 are reserved in an 8-bit stream, so no look-ahead needed
    assign code_byte_o = (byte_i == `TRS_FF) || (state_q != TRS_IDLE);
    assign xy_seen_o = byte_valid_i && (state_q == TRS_Z2);
    assign field_o = field_q;
    assign vblank_o = vblank_q;
    assign hblank_o = hblank_q;

    // ==================================================================
    // Preamble tracker
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= TRS_IDLE;
        end else if (byte_valid_i) begin
            case (state_q)
                TRS_IDLE: begin
                    if (byte_i == `TRS_FF) state_q <= TRS_FF1;
                end
                TRS_FF1: begin
                    state_q <= (byte_i == `TRS_00) ? TRS_Z1 : TRS_IDLE;
                end
                TRS_Z1: begin
                    state_q <= (byte_i == `TRS_00) ? TRS_Z2 : TRS_IDLE;
                end
                TRS_Z2: begin
                    state_q <= TRS_IDLE;
                end
                default: begin
                    state_q <= TRS_IDLE;
                end
            endcase
        end
    end

    // ==================================================================
    // Region flags, valid from the byte after the code word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            field_q <= 1'b0;
            vblank_q <= 1'b0;
            hblank_q <= 1'b1;
        end else if (xy_seen_o) begin
            field_q <= byte_i[`XY_F_BIT];
            vblank_q <= byte_i[`XY_V_BIT];
            hblank_q <= byte_i[`XY_H_BIT];
        end
    end

endmodule : trs_decoder
